/* File: hdl/ccem_top.sv */
// Background check of configuration frames with fault report.
// Assumes: cfg_rd_data answers cfg_rd_addr one cycle later; the
// frame word count is a power of two.
//
// Notes on behaviour
// - Checking starts by itself when enabled and user mode is entered.
// - Frames are checked in a loop until reset, reconfiguration or leaving user mode; a fault does not stop it.
// - Error pin stays low at least 32 cycles while a signature is computed.
// - Pin rises only after the report is updated and 32 cycles passed.
// - Pin stays high until the frame is read, then low 32 cycles minimum.
// - Report is readable from the core side and through the test port.
// - After reconfiguration the device carries on normally.
// - Test port takes the fault insertion instruction, code 00 0001 0101.
// - That instruction selects the fault insertion register holding the pattern.
// - Inserted faults are single bit or two adjacent bits only.
// - Faults land only in the first frame; later targets are ignored.
// - The report can be read at any time, also around insertion tests.
// - Zero signature keeps the pin low; nonzero raises it.
// - The 67-bit report is refreshed on every detected fault.
// - Type field: 0000 none, 0001 single, 0010 adjacent pair, 1111 other.
// - Insertion register: pattern 31:0, byte location 41:32, type 45:42.
`timescale 1ns/1ps
module ccem_top
  import ccem_pkg::*;
#(
  parameter int              FRAME_WORDS = 16,
  parameter int              NUM_FRAMES  = 4,
  parameter logic [IR_W-1:0] REPORT_CODE = REPORT_SHIFT_DEF,
  localparam int             WW          = $clog2(FRAME_WORDS),
  localparam int             FW          = $clog2(NUM_FRAMES),
  localparam int             AW          = WW + FW
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic             checker_enable,
  input  wire logic             user_mode,
  input  wire logic             reconfigure_request_n,
  output logic [AW-1:0]         cfg_rd_addr,
  input  wire logic [SIG_W-1:0] cfg_rd_data,
  output logic                  error_out,
  output logic [RPT_W-1:0]      user_report,
  input  wire logic             user_read_ack,
  input  wire logic [IR_W-1:0]  tap_ir,
  input  wire logic             tap_capture,
  input  wire logic             tap_shift,
  input  wire logic             tap_update,
  input  wire logic             tap_tdi,
  output logic                  tap_tdo
);

  typedef struct packed {
    ccem_state_t      st;
    logic [WW:0]      issue;
    logic             rd_vld;
    logic [WW-1:0]    rd_idx;
    logic [CYC_W-1:0] cyc;
    logic [FW-1:0]    frame;
    logic [SIG_W-1:0] acc;
    logic [AW-1:0]    addr;
    logic             err_pin;
    logic             rpt_load;
    logic [RPT_W-1:0] rpt;
  } ccem_scan_t;

  ccem_scan_t s_reg, s_next;
  ccem_rpt_if rif ();

  logic [SIG_W-1:0]  inj_pat;
  logic [WLOC_W-1:0] inj_word;
  logic [TYPE_W-1:0] inj_type;
  logic              inj_ok;
  logic [SIG_W-1:0]  inj_mask;

  // ----------------------------------------------------------------
  // Frame sequencing helper
  // ----------------------------------------------------------------
  // Moves on to the next frame, wrapping after the last one
  function automatic ccem_scan_t next_frame(input ccem_scan_t c);
    ccem_scan_t r;
    r       = c;
    r.st    = ST_CALC;
    r.issue = '0;
    r.cyc   = '0;
    r.acc   = '0;
    r.frame = (c.frame == FW'(NUM_FRAMES - 1)) ? '0 : c.frame + FW'(1);
    return r;
  endfunction : next_frame

  // ----------------------------------------------------------------
  // Fault insertion into the stored data as it is read
  // ----------------------------------------------------------------
  assign inj_pat  = rif.inj[INJ_PAT_LSB +: SIG_W];
  assign inj_word = rif.inj[INJ_LOC_LSB + BYTE_SEL_W +: WLOC_W];
  assign inj_type = rif.inj[INJ_TYPE_LSB +: TYPE_W];
  // Pattern must match its declared shape, else nothing is corrupted
  assign inj_ok   = rif.inj_armed && (inj_type == FT_SINGLE || inj_type == FT_DOUBLE)
                    && ccem_classify(inj_pat) == inj_type;
  // Word locations past the first frame never match a read index
  assign inj_mask = (inj_ok && s_reg.frame == '0 && s_reg.rd_vld
                     && inj_word == WLOC_W'(s_reg.rd_idx)) ? inj_pat : '0;

  // ----------------------------------------------------------------
  // Scanner state machine
  // ----------------------------------------------------------------
  always_comb begin
    s_next          = s_reg;
    s_next.rd_vld   = 1'b0;
    s_next.rpt_load = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        if (checker_enable) begin
          s_next       = next_frame(s_reg);
          s_next.frame = '0;
        end
      end
      ST_CALC: begin
        if (!s_reg.issue[WW]) begin
          s_next.addr   = {s_reg.frame, s_reg.issue[WW-1:0]};
          s_next.rd_vld = 1'b1;
          s_next.rd_idx = s_reg.issue[WW-1:0];
          s_next.issue  = s_reg.issue + (WW+1)'(1);
        end
        if (s_reg.rd_vld) s_next.acc = s_reg.acc ^ cfg_rd_data ^ inj_mask;
        if (s_reg.cyc != CYC_MAX) s_next.cyc = s_reg.cyc + CYC_W'(1);
        // Short frames are stretched so the pin stays low long enough
        if (s_reg.issue[WW] && !s_reg.rd_vld && s_reg.cyc >= MIN_LOW_CYC - CYC_W'(1))
          s_next.st = ST_CHECK;
      end
      ST_CHECK: begin
        if (s_reg.acc != '0) begin
          s_next.rpt      = {FRM_W'(s_reg.frame), s_reg.acc, ccem_classify(s_reg.acc)};
          s_next.rpt_load = 1'b1;
          s_next.st       = ST_FLAG;
        end else begin
          s_next = next_frame(s_reg);
        end
      end
      ST_FLAG: begin
        s_next.err_pin = 1'b1;
        s_next.st      = ST_HOLD;
      end
      ST_HOLD: begin
        if (rif.read_done) begin
          s_next         = next_frame(s_reg);
          s_next.err_pin = 1'b0;
        end
      end
      default: s_next = '0;
    endcase
    // Leaving user mode ends the loop; it restarts with the next entry
    if (!reconfigure_request_n || !user_mode) s_next = '0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) s_reg <= '0;
    else if (clk_en) s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs and report port
  // ----------------------------------------------------------------
  assign rif.rpt      = s_reg.rpt;
  assign rif.rpt_load = s_reg.rpt_load;
  assign rif.clear    = !reconfigure_request_n;
  assign cfg_rd_addr  = s_reg.addr;
  assign error_out    = s_reg.err_pin;

  ccem_report_port #(
    .REPORT_CODE (REPORT_CODE)
  ) u_port (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .clk_en        (clk_en),
    .rif           (rif.port),
    .user_report   (user_report),
    .user_read_ack (user_read_ack),
    .tap_ir        (tap_ir),
    .tap_capture   (tap_capture),
    .tap_shift     (tap_shift),
    .tap_update    (tap_update),
    .tap_tdi       (tap_tdi),
    .tap_tdo       (tap_tdo)
  );

  // ----------------------------------------------------------------
  // Checks (written for clk_en held high)
  // ----------------------------------------------------------------
  localparam int LOW_MIN = 32;
  logic [CYC_W-1:0] low_cnt;

  // Cycles the pin has been low, saturating
  always_ff @(posedge sys_clk) begin
    if (!rst_b || error_out) low_cnt <= '0;
    else if (low_cnt != CYC_MAX) low_cnt <= low_cnt + CYC_W'(1);
  end

  a_pin_low_gap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(error_out) |-> $past(low_cnt) >= CYC_W'(LOW_MIN)) else $error("pin low too short");
  a_calc_length: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_reg.st == ST_CHECK && $past(s_reg.st) == ST_CALC |-> $past(s_reg.cyc) >= CYC_W'(LOW_MIN - 1))
    else $error("calc shorter than minimum");
  a_rise_after_rpt: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(error_out) |-> $past(s_reg.rpt_load) && $past(s_reg.st, 2) == ST_CHECK)
    else $error("pin rose before report update");
  a_hold_until_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && error_out && !rif.read_done && reconfigure_request_n && user_mode |=> error_out)
    else $error("pin dropped before read");
  a_zero_sig_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && s_reg.st == ST_CHECK && s_reg.acc == '0 |=> !error_out && s_reg.st == ST_CALC)
    else $error("zero signature flagged");
  a_sig_flags: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && s_reg.st == ST_CHECK && s_reg.acc != '0 && reconfigure_request_n && user_mode
    ##1 clk_en && reconfigure_request_n && user_mode |=> error_out) else $error("fault not flagged");
  a_rpt_update: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && s_reg.st == ST_CHECK && s_reg.acc != '0 && reconfigure_request_n && user_mode
    |=> rif.rpt_load && rif.rpt[RPT_SIG_LSB +: SIG_W] == $past(s_reg.acc)) else $error("report not updated");
  a_type_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rif.rpt_load |-> rif.rpt[RPT_TYPE_LSB +: TYPE_W] == ccem_classify(rif.rpt[RPT_SIG_LSB +: SIG_W]))
    else $error("bad fault type");
  a_autostart: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && s_reg.st == ST_IDLE && checker_enable && user_mode && reconfigure_request_n
    |=> s_reg.st == ST_CALC) else $error("no automatic start");
  a_keeps_cycling: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && s_reg.st == ST_HOLD && rif.read_done && reconfigure_request_n && user_mode
    |=> s_reg.st == ST_CALC && !error_out) else $error("loop stopped after fault");
  a_reconf_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && !reconfigure_request_n |=> s_reg.st == ST_IDLE && !error_out) else $error("not cleared");
  a_inject_first: assert property (@(posedge sys_clk) disable iff (!rst_b)
    inj_mask != '0 |-> s_reg.frame == '0) else $error("fault outside first frame");

  c_fault_flag: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(error_out));
  c_fault_clear: cover property (@(posedge sys_clk) disable iff (!rst_b) $fell(error_out));
  c_injected: cover property (@(posedge sys_clk) disable iff (!rst_b) inj_mask != '0);

endmodule : ccem_top

/* File: hdl/ccem_pkg.sv */
// Shared constants, state encoding and fault classifier for the
// configuration check monitor.
// Assumes: included first by every design file of the block.
package ccem_pkg;

  // ----------------------------------------------------------------
  // Widths and field layout
  // ----------------------------------------------------------------
  localparam int RPT_W        = 67;
  localparam int INJ_W        = 46;
  localparam int SIG_W        = 32;
  localparam int IR_W         = 10;
  localparam int TYPE_W       = 4;
  localparam int FRM_W        = RPT_W - SIG_W - TYPE_W;
  localparam int RPT_TYPE_LSB = 0;
  localparam int RPT_SIG_LSB  = 4;
  localparam int RPT_FRM_LSB  = 36;
  localparam int INJ_PAT_LSB  = 0;
  localparam int INJ_LOC_LSB  = 32;
  localparam int INJ_LOC_W    = 10;
  localparam int INJ_TYPE_LSB = 42;
  localparam int BYTE_SEL_W   = 2;
  localparam int WLOC_W       = INJ_LOC_W - BYTE_SEL_W;
  localparam int CYC_W        = 6;
  localparam int SCNT_W       = 7;

  // ----------------------------------------------------------------
  // Codes and timing
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0]   FAULT_INSERT_CODE  = 10'h015;
  localparam logic [IR_W-1:0]   REPORT_SHIFT_DEF   = 10'h016;
  localparam logic [CYC_W-1:0]  MIN_LOW_CYC        = 6'h20;
  localparam logic [CYC_W-1:0]  CYC_MAX            = 6'h3F;
  localparam logic [SCNT_W-1:0] RPT_LAST_SHIFT     = 7'h42;
  localparam logic [TYPE_W-1:0] FT_NONE            = 4'h0;
  localparam logic [TYPE_W-1:0] FT_SINGLE          = 4'h1;
  localparam logic [TYPE_W-1:0] FT_DOUBLE          = 4'h2;
  localparam logic [TYPE_W-1:0] FT_OTHER           = 4'hF;

  // Gray steps along idle, calc, check, flag, hold
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CALC  = 3'h1,
    ST_CHECK = 3'h3,
    ST_FLAG  = 3'h2,
    ST_HOLD  = 3'h6
  } ccem_state_t;

  // Classifies a signature or a fault pattern
  function automatic logic [TYPE_W-1:0] ccem_classify(input logic [SIG_W-1:0] v);
    logic [SIG_W-1:0]  pair;
    logic [TYPE_W-1:0] t;
    pair = v & (v >> 1);
    if (v == '0) t = FT_NONE;
    else if ((v & (v - SIG_W'(1))) == '0) t = FT_SINGLE;
    else if (pair != '0 && (pair & (pair - SIG_W'(1))) == '0 && (pair | (pair << 1)) == v) t = FT_DOUBLE;
    else t = FT_OTHER;
    return t;
  endfunction : ccem_classify

endpackage : ccem_pkg

/* File: hdl/ccem_rpt_if.sv */
// Carrier between the frame scanner and the report/test port.
// Assumes: both ends run on the same sys_clk.
`timescale 1ns/1ps
interface ccem_rpt_if;
  import ccem_pkg::*;
  logic [RPT_W-1:0] rpt;
  logic             rpt_load;
  logic             clear;
  logic             read_done;
  logic [INJ_W-1:0] inj;
  logic             inj_armed;
  modport scan (output rpt, rpt_load, clear, input read_done, inj, inj_armed);
  modport port (input rpt, rpt_load, clear, output read_done, inj, inj_armed);
endinterface : ccem_rpt_if

/* File: hdl/ccem_report_port.sv */
// Fault report copies for core and test port, and the fault
// insertion register loaded through the test port.
// Assumes: test port strobes are synchronous one-cycle pulses.
`timescale 1ns/1ps
module ccem_report_port
  import ccem_pkg::*;
#(
  parameter logic [IR_W-1:0] REPORT_CODE = REPORT_SHIFT_DEF
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic            clk_en,
  ccem_rpt_if.port             rif,
  output logic [RPT_W-1:0]     user_report,
  input  wire logic            user_read_ack,
  input  wire logic [IR_W-1:0] tap_ir,
  input  wire logic            tap_capture,
  input  wire logic            tap_shift,
  input  wire logic            tap_update,
  input  wire logic            tap_tdi,
  output logic                 tap_tdo
);

  typedef struct packed {
    logic [RPT_W-1:0]  user_upd;
    logic [RPT_W-1:0]  tap_upd;
    logic [RPT_W-1:0]  tap_sh;
    logic [SCNT_W-1:0] cnt;
    logic [INJ_W-1:0]  inj_sh;
    logic [INJ_W-1:0]  inj;
    logic              armed;
    logic              done;
    logic              tdo;
  } ccem_port_t;

  ccem_port_t s_reg, s_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next        = s_reg;
    s_next.done   = 1'b0;
    // Copies follow the report one cycle after it is valid, so they
    // are already current when the error pin rises
    if (rif.rpt_load) begin
      s_next.user_upd = rif.rpt;
      s_next.tap_upd  = rif.rpt;
    end
    if (user_read_ack) s_next.done = 1'b1;
    if (tap_ir == REPORT_CODE) begin
      if (tap_capture) begin
        s_next.tap_sh = s_reg.tap_upd;
        s_next.cnt    = '0;
      end else if (tap_shift) begin
        s_next.tap_sh = {tap_tdi, s_reg.tap_sh[RPT_W-1:1]};
        s_next.cnt    = s_reg.cnt + SCNT_W'(1);
        // Last bit out counts as the frame being read
        if (s_reg.cnt == RPT_LAST_SHIFT) s_next.done = 1'b1;
      end
      s_next.tdo = s_next.tap_sh[0];
    end else if (tap_ir == FAULT_INSERT_CODE) begin
      if (tap_capture) s_next.inj_sh = s_reg.inj;
      else if (tap_shift) s_next.inj_sh = {tap_tdi, s_reg.inj_sh[INJ_W-1:1]};
      else if (tap_update) begin
        s_next.inj   = s_reg.inj_sh;
        s_next.armed = 1'b1;
      end
      s_next.tdo = s_next.inj_sh[0];
    end
    // Reconfiguration wipes stored report and pending fault
    if (rif.clear) begin
      s_next.user_upd = '0;
      s_next.tap_upd  = '0;
      s_next.inj      = '0;
      s_next.armed    = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) s_reg <= '0;
    else if (clk_en) s_reg <= s_next;
  end

  assign rif.read_done = s_reg.done;
  assign rif.inj       = s_reg.inj;
  assign rif.inj_armed = s_reg.armed;
  assign user_report   = s_reg.user_upd;
  assign tap_tdo       = s_reg.tdo;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_insert_arms: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && tap_ir == FAULT_INSERT_CODE && tap_update && !tap_capture && !tap_shift && !rif.clear
    |=> rif.inj_armed && rif.inj == $past(s_reg.inj_sh)) else $error("insert not armed");
  a_report_copy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && rif.rpt_load && !rif.clear
    |=> user_report == $past(rif.rpt)) else $error("report copy missing");
  c_tap_read: cover property (@(posedge sys_clk) disable iff (!rst_b)
    tap_ir == REPORT_CODE && tap_shift && s_reg.cnt == RPT_LAST_SHIFT);

endmodule : ccem_report_port

/* File: verification/ccem_cfg_mem.sv */
// Configuration memory model feeding the frame scanner.
// Assumes: the address comes from a flop; its word stands while it does.
`timescale 1ns/1ps
module ccem_cfg_mem
  import ccem_pkg::*;
#(
  parameter int FRAME_WORDS = 16,
  parameter int NUM_FRAMES  = 4,
  parameter int AW          = 6
) (
  input  wire logic             sys_clk,
  input  wire logic [AW-1:0]    cfg_rd_addr,
  input  wire logic [AW-1:0]    flip_addr,
  input  wire logic [SIG_W-1:0] flip_mask,
  output logic [SIG_W-1:0]      cfg_rd_data
);
  // ----------------------------------------------------------------
  // Frame contents
  // ----------------------------------------------------------------
  logic [SIG_W-1:0] mem [FRAME_WORDS*NUM_FRAMES];

  // Last word closes each frame's XOR sum to zero; words are varied,
  // though a stuck data bus still sums to zero over the even word count
  initial begin
    for (int f = 0; f < NUM_FRAMES; f++) begin
      mem[f*FRAME_WORDS+FRAME_WORDS-1] = '0;
      for (int w = 0; w < FRAME_WORDS-1; w++) begin
        mem[f*FRAME_WORDS+w] = 32'h5A3C_0000 ^ (SIG_W'(f*FRAME_WORDS+w) * 32'h0101_0107);
        mem[f*FRAME_WORDS+FRAME_WORDS-1] ^= mem[f*FRAME_WORDS+w];
      end
    end
  end

  // Read of the registered address; the scanner takes it at the next
  // edge, which is the one-cycle latency it expects. One word may be corrupted
  assign cfg_rd_data = mem[cfg_rd_addr] ^ ((cfg_rd_addr == flip_addr) ? flip_mask : '0);
endmodule : ccem_cfg_mem

/* File: verification/tb_config_crc_error_monitor.sv */
// Bench for the configuration check monitor: scan, reads, insertion, reconfig.
// Assumes: package, carrier interface and design modules compiled first.
`timescale 1ns/1ps
module tb_config_crc_error_monitor
  import ccem_pkg::*;
;
  localparam int FWORDS = 16;
  localparam int NFR    = 4;
  localparam int AW     = $clog2(FWORDS) + $clog2(NFR);

  logic             sys_clk = 1'b0;
  logic             rst_b, clk_en, checker_enable, user_mode, reconfigure_request_n;
  logic [AW-1:0]    cfg_rd_addr, flip_addr;
  logic [SIG_W-1:0] cfg_rd_data, flip_mask;
  logic             error_out, user_read_ack, tap_capture, tap_shift, tap_update, tap_tdi, tap_tdo;
  logic [RPT_W-1:0] user_report, dout;
  logic [IR_W-1:0]  tap_ir;
  int               num_errors = 0;
  int               n_compared = 0;
  int               low_cnt    = 0;

  always #12.5 sys_clk = ~sys_clk;

  ccem_top #(.FRAME_WORDS(FWORDS), .NUM_FRAMES(NFR)) ccem_top_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .checker_enable(checker_enable),
    .user_mode(user_mode), .reconfigure_request_n(reconfigure_request_n),
    .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data), .error_out(error_out),
    .user_report(user_report), .user_read_ack(user_read_ack), .tap_ir(tap_ir),
    .tap_capture(tap_capture), .tap_shift(tap_shift), .tap_update(tap_update),
    .tap_tdi(tap_tdi), .tap_tdo(tap_tdo));

  ccem_cfg_mem #(.FRAME_WORDS(FWORDS), .NUM_FRAMES(NFR), .AW(AW)) ccem_cfg_mem_i (
    .sys_clk(sys_clk), .cfg_rd_addr(cfg_rd_addr), .flip_addr(flip_addr),
    .flip_mask(flip_mask), .cfg_rd_data(cfg_rd_data));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic chk(input logic [RPT_W-1:0] got, input logic [RPT_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // Low stretch before every rise must be at least 32 cycles
  always @(negedge sys_clk) begin
    if (error_out === 1'b1) begin
      if (low_cnt != 0) chk(RPT_W'(low_cnt >= 32), RPT_W'(1));
      low_cnt = 0;
    end else low_cnt = low_cnt + 1;
  end

  // Bounded wait on the pin; a miss ends the run
  task automatic wait_level(input logic lvl, input int bound);
    int k;
    k = 0;
    while (error_out !== lvl && k < bound) begin
      tick();
      k++;
    end
    if (error_out !== lvl) begin
      chk(RPT_W'(error_out), RPT_W'(lvl));
      give_verdict();
    end
  endtask : wait_level

  task automatic stay_low(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      tick();
      seen |= (error_out !== 1'b0);
    end
    chk(RPT_W'(seen), '0);
  endtask : stay_low

  function automatic logic [RPT_W-1:0] exp_rpt(input int fr, input logic [SIG_W-1:0] m,
                                               input logic [TYPE_W-1:0] t);
    return {FRM_W'(fr), m, t};
  endfunction : exp_rpt

  // Capture, n shifts LSB first, optional update
  task automatic tap_xfer(input logic [IR_W-1:0] ir, input logic [RPT_W-1:0] din, input int n,
                          input logic upd);
    tap_ir = ir;
    tap_capture = 1'b1;
    tick();
    tap_capture = 1'b0;
    for (int k = 0; k < n; k++) begin
      dout[k] = tap_tdo;
      tap_shift = 1'b1;
      tap_tdi = din[k];
      tick();
    end
    tap_shift = 1'b0;
    tap_update = upd;
    tick();
    tap_update = 1'b0;
  endtask : tap_xfer

  task automatic insert(input logic [3:0] t, input logic [9:0] loc, input logic [31:0] pat);
    tap_xfer(10'h015, RPT_W'({t, loc, pat}), INJ_W, 1'b1);
  endtask : insert

  // Core read done; pin must drop promptly
  task automatic ack;
    user_read_ack = 1'b1;
    tick();
    user_read_ack = 1'b0;
    wait_level(1'b0, 8);
  endtask : ack

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_enable;
    flip_addr = AW'(2*FWORDS + 5);
    flip_mask = 32'h0000_0100;
    stay_low(100);
    chk(RPT_W'(cfg_rd_addr), '0);
    checker_enable = 1'b1;
    user_mode = 1'b1;
    wait_level(1'b1, 2000);
    chk(user_report, exp_rpt(2, 32'h0000_0100, 4'h1));
  endtask : sc_enable

  // Frozen clock enable must not let an acknowledge through
  task automatic sc_core_read;
    clk_en = 1'b0;
    user_read_ack = 1'b1;
    tick(40);
    user_read_ack = 1'b0;
    chk(RPT_W'(error_out), RPT_W'(1));
    clk_en = 1'b1;
    tick(3);
    chk(RPT_W'(error_out), RPT_W'(1));
    ack();
    wait_level(1'b1, 2000);
    tick();
    chk(user_report, exp_rpt(2, 32'h0000_0100, 4'h1));
  endtask : sc_core_read

  task automatic sc_tap_read;
    tap_xfer(REPORT_SHIFT_DEF, '0, RPT_W, 1'b0);
    chk(dout, exp_rpt(2, 32'h0000_0100, 4'h1));
    wait_level(1'b0, 8);
  endtask : sc_tap_read

  task automatic sc_types;
    logic [SIG_W-1:0]  masks [2] = '{32'h0000_0C00, 32'h0001_0001};
    logic [TYPE_W-1:0] types [2] = '{4'h2, 4'hF};
    for (int i = 0; i < 2; i++) begin
      flip_mask = masks[i];
      wait_level(1'b1, 2000);
      tick();
      chk(user_report, exp_rpt(2, masks[i], types[i]));
      ack();
    end
  endtask : sc_types

  // Good insertion, then refused type and out-of-frame target
  task automatic sc_inject;
    logic [TYPE_W-1:0] bad_t   [2] = '{4'hF, 4'h1};
    logic [9:0]        bad_loc [2] = '{10'h00C, 10'h040};
    flip_mask = '0;
    insert(4'h1, 10'h00C, 32'h0000_0020);
    wait_level(1'b1, 2000);
    tick();
    chk(user_report, exp_rpt(0, 32'h0000_0020, 4'h1));
    for (int i = 0; i < 2; i++) begin
      insert(bad_t[i], bad_loc[i], 32'h0000_0001);
      ack();
      stay_low(400);
    end
  endtask : sc_inject

  task automatic sc_reconfig;
    insert(4'h2, 10'h008, 32'h0000_0006);
    wait_level(1'b1, 2000);
    tick();
    chk(user_report, exp_rpt(0, 32'h0000_0006, 4'h2));
    reconfigure_request_n = 1'b0;
    tick(3);
    chk(RPT_W'(error_out), '0);
    chk(user_report, '0);
    reconfigure_request_n = 1'b1;
    stay_low(400);
    flip_addr = AW'(FWORDS);
    flip_mask = 32'h8000_0000;
    wait_level(1'b1, 2000);
    tick();
    chk(user_report, exp_rpt(1, 32'h8000_0000, 4'h1));
  endtask : sc_reconfig

  // Main sequence
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    checker_enable = 1'b0;
    user_mode = 1'b0;
    reconfigure_request_n = 1'b1;
    user_read_ack = 1'b0;
    tap_ir = 10'h3FF;
    {tap_capture, tap_shift, tap_update, tap_tdi} = 4'h0;
    flip_addr = '0;
    flip_mask = '0;
    tick(3);
    chk(RPT_W'({error_out, tap_tdo}), '0);
    chk(user_report, '0);
    rst_b = 1'b1;
    sc_enable();
    sc_core_read();
    sc_tap_read();
    sc_types();
    sc_inject();
    sc_reconfig();
    give_verdict();
  end
endmodule : tb_config_crc_error_monitor
